// File: bench/tlac_grabber.sv
// Frame grabber model that records the columns of each received line
module tlac_grabber (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Line stream
  input  wire logic        line_start,
  input  wire logic        pix_valid,
  input  wire logic [11:0] pix_col,
  // Per-line record
  output logic      [11:0] first_col,
  output logic      [11:0] last_col,
  output logic      [11:0] pix_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Count only qualified pixels; a new line restarts the record
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_col <= 12'h000;
      last_col  <= 12'h000;
      pix_cnt   <= 12'h000;
    end else if (line_start) begin
      first_col <= pix_col;
      last_col  <= pix_col;
      pix_cnt   <= {11'h000, pix_valid};
    end else if (pix_valid) begin
      last_col <= pix_col;
      pix_cnt  <= pix_cnt + 12'h001;
    end
  end
endmodule // tlac_grabber

// File: bench/tlac_top_assertions.sv
// Port-level checks for the acquisition control readout outputs
module tlac_top_assertions
  import tlac_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  // Readout outputs
  input wire logic        line_start,
  input wire logic        pix_valid,
  input wire logic [11:0] pix_col,
  input wire logic [6:0]  row_index,
  input wire logic        row_reverse,
  input wire logic        scan_reverse,
  input wire logic [6:0]  accum_stages,
  input wire logic        area_mode
);
  // ==========================================================================
  // Checks, one clock domain
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  col_step_a: assert property (pix_valid && !line_start && $past(pix_valid) |->
    pix_col == $past(pix_col) + 12'h001) else $error("column not ascending");
  start_pix_a: assert property (line_start |-> pix_valid)
    else $error("line start without pixel");
  rose_pix_a: assert property ($rose(pix_valid) |-> line_start)
    else $error("pixels began without line start");
  line_gap_a: assert property (line_start |=> !line_start [*8])
    else $error("lines overlap");
  pix_range_a: assert property (pix_valid |-> pix_col < SENSOR_W)
    else $error("column beyond sensor");
  area_stage_a: assert property (area_mode |-> accum_stages == 7'h01)
    else $error("area mode still accumulating");
  // Registered outputs settle one edge after reset leaves
  tdi_stage_a: assert property (!area_mode && !$past(sys_rst) && !$past(sys_rst, 2) |->
    accum_stages inside {7'h14, 7'h28, 7'h3c, 7'h50}) else $error("bad stage count");
  row_rev_a: assert property (row_reverse |-> area_mode && scan_reverse)
    else $error("mirror outside area reverse");
  row_range_a: assert property (area_mode |-> row_index < 7'h50)
    else $error("row beyond height");
endmodule // tlac_top_assertions

bind tlac_top tlac_top_assertions u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .line_start(line_start),
  .pix_valid(pix_valid), .pix_col(pix_col), .row_index(row_index),
  .row_reverse(row_reverse), .scan_reverse(scan_reverse),
  .accum_stages(accum_stages), .area_mode(area_mode)
);

// File: bench/tlac_top_tb.sv
// Self-checking bench for the acquisition control block
module tlac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        trig_in = 1'b0;
  logic        dir_line_in = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, d;
  logic        line_start, pix_valid, row_reverse, scan_reverse, area_mode;
  logic [11:0] pix_col, first_col, last_col, pix_cnt;
  logic [6:0]  row_index, accum_stages;
  int          failures = 0;
  int          total_checks = 0;

  // ==========================================================================
  // Clock, design and far-side model
  always #5 core_clk = ~core_clk;
  tlac_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_in(trig_in), .dir_line_in(dir_line_in), .line_start(line_start),
    .pix_valid(pix_valid), .pix_col(pix_col), .row_index(row_index),
    .row_reverse(row_reverse), .scan_reverse(scan_reverse),
    .accum_stages(accum_stages), .area_mode(area_mode));
  tlac_grabber u_grab (.core_clk(core_clk), .sys_rst(sys_rst), .line_start(line_start),
    .pix_valid(pix_valid), .pix_col(pix_col), .first_col(first_col),
    .last_col(last_col), .pix_cnt(pix_cnt));

  // ==========================================================================
  // Bus cycles and comparison
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd(8'h04);
    chk(d, 32'h0870_0000);
    rd(8'h3c);
    chk(d, 32'h0);
    chk({25'h0, accum_stages}, 32'h50);
  endtask
  task automatic t_stages;
    for (int c = 1; c <= 4; c++) begin
      wr(8'h00, 32'(c) << 4);
      chk({25'h0, accum_stages}, 32'(c) * 32'h14);
    end
    wr(8'h00, 32'h0); // code 0 refused, previous stays
    chk({25'h0, accum_stages}, 32'h50);
  endtask
  task automatic t_dir;
    wr(8'h00, 32'h0000_0141);
    chk({29'h0, area_mode, row_reverse, accum_stages == 7'h01}, 32'h7);
    wr(8'h00, 32'h0000_0240);
    dir_line_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk({30'h0, area_mode, scan_reverse}, 32'h1);
    dir_line_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({31'h0, scan_reverse}, 32'h0);
  endtask
  task automatic ceil(input logic [1:0] t, input logic [11:0] w, input logic [9:0] e);
    wr(8'h00, {18'h0, t, 12'h040});
    wr(8'h04, {4'h0, w, 16'h0000});
    rd(8'h28);
    chk({22'h0, d[13:4]}, {22'h0, e});
  endtask
  task automatic t_roi;
    wr(8'h08, 32'h03e8_0000);
    wr(8'h04, 32'h0030_0030);
    @(posedge line_start);
    repeat (60) @(posedge core_clk);
    chk({first_col, last_col, 8'h00}, 32'h0300_5f00);
    chk({20'h0, pix_cnt}, 32'h30);
  endtask
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n) begin
      trig_in <= 1'b1;
      repeat (hi) @(posedge core_clk);
      trig_in <= 1'b0;
      repeat (lo) @(posedge core_clk);
    end
  endtask
  task automatic t_stats;
    wr(8'h08, 32'h0000_0001);
    pulses(4, 500, 500);
    rd(8'h10);
    chk(d, 32'h0001_86a0);
    rd(8'h18);
    chk(d, 32'h0);
    rd(8'h1c);
    chk(d, 32'h5);
    pulses(3, 1000, 1000);
    rd(8'h10);
    chk(d, 32'h0000_c350);
    rd(8'h14);
    chk(d, 32'h0001_86a0);
    rd(8'h20);
    chk(d, 32'h0000_c350);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_stages();
    t_dir();
    ceil(2'h0, 12'h2d0, 10'h30d);
    ceil(2'h0, 12'h870, 10'h102);
    ceil(2'h1, 12'h870, 10'h17a);
    ceil(2'h2, 12'h870, 10'h203);
    ceil(2'h3, 12'h870, 10'h3e8);
    ceil(2'h0, 12'h210, 10'h3e8);
    t_roi();
    t_stats();
    finish_test();
  end
  // Tests need about 11000 cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    finish_test();
  end
endmodule // tlac_top_tb

// File: design/tlac_pkg.sv
// Package of constants and carriers for the TDI line acquisition control block
// ==========================================================================
package tlac_pkg;

  // ==========================================================================
  // Clock and time
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned CLK_PER_US  = CLK_HZ / 1_000_000;
  localparam logic [31:0] TIMEOUT_CYC = 32'h05f5_e100;  // one second of clock

  // ==========================================================================
  // Sensor geometry
  localparam logic [11:0] SENSOR_W    = 12'h870;   // 2160 pixels
  localparam logic [11:0] ROI_STEP    = 12'h030;   // 48 pixels
  localparam logic [11:0] RST_OFFSET  = 12'h000;
  localparam logic [11:0] RST_WIDTH   = 12'h870;
  localparam logic [6:0]  STAGE_STEP  = 7'h14;     // 20 stages per code
  localparam logic [2:0]  RST_STAGES  = 3'h4;

  // ==========================================================================
  // Rescaler factor: unsigned fixed point, 16 fractional bits
  localparam int unsigned RS_FRAC     = 16;
  localparam logic [23:0] RS_MIN      = 24'h00028f;   // 0.01
  localparam logic [23:0] RS_MAX      = 24'h640000;   // 100.0
  localparam logic [23:0] RS_UNITY    = 24'h010000;

  // ==========================================================================
  // Line rate ceilings in units of 100 Hz, width rows then tap columns
  localparam logic [11:0] W_384  = 12'h180;
  localparam logic [11:0] W_528  = 12'h210;
  localparam logic [11:0] W_720  = 12'h2d0;
  localparam logic [11:0] W_1056 = 12'h420;
  localparam logic [11:0] W_1536 = 12'h600;
  localparam logic [9:0]  R_1000 = 10'h3e8;  // 100.0 kHz
  localparam logic [9:0]  R_781  = 10'h30d;
  localparam logic [9:0]  R_534  = 10'h216;
  localparam logic [9:0]  R_798  = 10'h31e;
  localparam logic [9:0]  R_367  = 10'h16f;
  localparam logic [9:0]  R_551  = 10'h227;
  localparam logic [9:0]  R_732  = 10'h2dc;
  localparam logic [9:0]  R_258  = 10'h102;
  localparam logic [9:0]  R_378  = 10'h17a;
  localparam logic [9:0]  R_515  = 10'h203;
  localparam logic [9:0]  RST_FREE_RATE = 10'h0c8;  // 20.0 kHz

  // ==========================================================================
  // Settings encodings
  typedef enum logic [1:0] { TAP_2, TAP_3, TAP_4, TAP_8_10 } tlac_tap_e;
  typedef enum logic { OPM_TDI, OPM_AREA } tlac_opm_e;
  typedef enum logic [1:0] { DIR_FWD, DIR_REV, DIR_EXT, DIR_RSVD } tlac_dir_e;
  typedef enum logic [1:0] { EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_RSVD } tlac_edge_e;

  // Configuration carrier
  typedef struct packed {
    tlac_opm_e   op_mode;
    logic [2:0]  stage_code;
    tlac_dir_e   direction;
    logic [11:0] offset_x;
    logic [11:0] width;
    tlac_tap_e   taps;
    logic        trig_mode_on;   // 0: free run
    tlac_edge_e  activation;
    logic [9:0]  free_rate;      // 100 Hz units
    logic [23:0] rescale;
  } tlac_cfg_s;

  // Statistics carrier
  typedef struct packed {
    logic [31:0] freq_hz;
    logic [31:0] freq_peak_hz;
    logic [7:0]  variation_pct;
    logic [31:0] width_us;
  } tlac_stat_s;

  // Rate ceiling lookup, 100 Hz units
  function automatic logic [9:0] tlac_ceiling(input logic [11:0] w, input tlac_tap_e t);
    logic [9:0] r;
    r = R_1000;
    if (t != TAP_8_10) begin
      if (w <= W_528)
        r = R_1000;
      else if (w <= W_720)
        r = (t == TAP_2) ? R_781 : R_1000;
      else if (w <= W_1056)
        r = (t == TAP_2) ? R_534 : (t == TAP_3) ? R_798 : R_1000;
      else if (w <= W_1536)
        r = (t == TAP_2) ? R_367 : (t == TAP_3) ? R_551 : R_732;
      else
        r = (t == TAP_2) ? R_258 : (t == TAP_3) ? R_378 : R_515;
    end
    return r;
  endfunction

endpackage

// File: design/tlac_top.sv
// Acquisition control: settings, trigger path, rate ceiling, ROI and readout sequencing
module tlac_top
  import tlac_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Trigger and direction inputs
  input  wire logic        trig_in,
  input  wire logic        dir_line_in,
  // Line readout control
  output logic             line_start,
  output logic             pix_valid,
  output logic      [11:0] pix_col,
  output logic      [6:0]  row_index,
  output logic             row_reverse,
  output logic             scan_reverse,
  output logic      [6:0]  accum_stages,
  output logic             area_mode
);

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_ROI     = 8'h04;
  localparam logic [7:0] A_TRIG    = 8'h08;
  localparam logic [7:0] A_RESCALE = 8'h0c;
  localparam logic [7:0] A_IN_FREQ = 8'h10;
  localparam logic [7:0] A_IN_PEAK = 8'h14;
  localparam logic [7:0] A_IN_VAR  = 8'h18;
  localparam logic [7:0] A_IN_PW   = 8'h1c;
  localparam logic [7:0] A_SC_FREQ = 8'h20;
  localparam logic [7:0] A_SC_VAR  = 8'h24;
  localparam logic [7:0] A_STATUS  = 8'h28;

  tlac_cfg_s   cfg_q;
  logic [31:0] rdata_q;
  logic        trig_q;
  logic [31:0] free_cnt_q;
  logic [31:0] in_per_q;
  logic [31:0] in_cnt_q;
  logic [31:0] sc_cnt_q;
  logic        sc_level_q;
  logic [11:0] col_q;
  logic        run_q;
  logic [6:0]  row_q;
  logic        line_start_q;
  tlac_stat_s  in_stat;
  tlac_stat_s  sc_stat;

  typedef enum logic [1:0] { RD_IDLE, RD_PIX } tlac_rd_e;
  tlac_rd_e    rd_q;
  tlac_rd_e    rd_d;

  // ==========================================================================
  // Decoded settings
  wire [6:0]  stages     = 7'(cfg_q.stage_code * STAGE_STEP);
  wire        is_area    = cfg_q.op_mode == OPM_AREA;
  wire        dir_rev    = (cfg_q.direction == DIR_REV)
                         || (cfg_q.direction == DIR_EXT && dir_line_in);
  wire [9:0]  ceiling    = tlac_ceiling(cfg_q.width, cfg_q.taps);
  wire [9:0]  eff_rate   = (cfg_q.free_rate > ceiling) ? ceiling : cfg_q.free_rate;
  wire [31:0] free_per   = CLK_HZ / ({22'h0, (eff_rate == 10'h0) ? 10'h1 : eff_rate} * 32'd100);
  wire [11:0] roi_end    = cfg_q.offset_x + cfg_q.width;

  // Edge qualification of the input trigger
  wire rise     = trig_in && !trig_q;
  wire fall     = !trig_in && trig_q;
  wire in_event = cfg_q.trig_mode_on &&
                  ((cfg_q.activation == EDGE_RISE && rise) ||
                   (cfg_q.activation == EDGE_FALL && fall) ||
                   (cfg_q.activation == EDGE_BOTH && (rise || fall)));

  // Rescaled period: input period divided by factor (clamped to its legal range)
  wire [23:0] factor   = (cfg_q.rescale < RS_MIN) ? RS_MIN
                       : (cfg_q.rescale > RS_MAX) ? RS_MAX : cfg_q.rescale;
  wire [47:0] per_num  = {in_per_q, 16'h0000};
  wire [31:0] sc_per_w = 32'(per_num / {24'h0, factor});
  wire        sc_event = cfg_q.trig_mode_on && in_per_q != 32'h0
                       && sc_cnt_q >= sc_per_w;
  wire        free_evt = !cfg_q.trig_mode_on && free_cnt_q >= free_per;
  wire        line_evt = free_evt || (cfg_q.trig_mode_on && sc_event);

  // Register write decode
  wire w_ctrl    = reg_wr && reg_addr == A_CTRL;
  wire w_roi     = reg_wr && reg_addr == A_ROI;
  wire w_trig    = reg_wr && reg_addr == A_TRIG;
  wire w_rescale = reg_wr && reg_addr == A_RESCALE;

  // Configuration registers; ROI resets to full sensor width
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q            <= '0;
      cfg_q.stage_code <= RST_STAGES;
      cfg_q.offset_x   <= RST_OFFSET;
      cfg_q.width      <= RST_WIDTH;
      cfg_q.taps       <= TAP_8_10;
      cfg_q.free_rate  <= RST_FREE_RATE;
      cfg_q.rescale    <= RS_UNITY;
    end else begin
      if (w_ctrl) begin
        cfg_q.op_mode    <= tlac_opm_e'(reg_wdata[0]);
        cfg_q.stage_code <= (reg_wdata[6:4] >= 3'h1 && reg_wdata[6:4] <= 3'h4)
                            ? reg_wdata[6:4] : cfg_q.stage_code;
        cfg_q.direction  <= tlac_dir_e'(reg_wdata[9:8]);
        cfg_q.taps       <= tlac_tap_e'(reg_wdata[13:12]);
      end
      if (w_roi) begin
        cfg_q.offset_x <= reg_wdata[11:0];
        cfg_q.width    <= reg_wdata[27:16];
      end
      if (w_trig) begin
        cfg_q.trig_mode_on <= reg_wdata[0];
        cfg_q.activation   <= tlac_edge_e'(reg_wdata[5:4]);
        cfg_q.free_rate    <= reg_wdata[25:16];
      end
      if (w_rescale)
        cfg_q.rescale <= reg_wdata[23:0];
    end
  end

  // Read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
      (reg_addr == A_CTRL)    ? {18'h0, cfg_q.taps, 2'h0, cfg_q.direction, 1'b0,
                                 cfg_q.stage_code, 3'h0, cfg_q.op_mode} :
      (reg_addr == A_ROI)     ? {4'h0, cfg_q.width, 4'h0, cfg_q.offset_x} :
      (reg_addr == A_TRIG)    ? {6'h0, cfg_q.free_rate, 10'h0, cfg_q.activation,
                                 3'h0, cfg_q.trig_mode_on} :
      (reg_addr == A_RESCALE) ? {8'h0, cfg_q.rescale} :
      (reg_addr == A_IN_FREQ) ? in_stat.freq_hz :
      (reg_addr == A_IN_PEAK) ? in_stat.freq_peak_hz :
      (reg_addr == A_IN_VAR)  ? {24'h0, in_stat.variation_pct} :
      (reg_addr == A_IN_PW)   ? in_stat.width_us :
      (reg_addr == A_SC_FREQ) ? sc_stat.freq_hz :
      (reg_addr == A_SC_VAR)  ? {24'h0, sc_stat.variation_pct} :
      (reg_addr == A_STATUS)  ? {5'h0, row_q, 6'h0, ceiling, 2'h0, dir_rev, run_q} :
      32'h0000_0000;

  // Read data registered, stands one cycle only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  // ==========================================================================
  // Trigger timing: input period, rescaled generator, free run generator
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_q     <= 1'b0;
      in_cnt_q   <= 32'h0;
      in_per_q   <= 32'h0;
      sc_cnt_q   <= 32'h0;
      free_cnt_q <= 32'h0;
    end else begin
      trig_q     <= trig_in;
      in_cnt_q   <= in_event ? 32'h1 : (in_cnt_q == TIMEOUT_CYC ? in_cnt_q : in_cnt_q + 32'h1);
      if (in_event)
        in_per_q <= in_cnt_q;
      else if (in_cnt_q == TIMEOUT_CYC)
        in_per_q <= 32'h0;  // stream stopped, stop rescaled output too
      sc_cnt_q   <= sc_event ? 32'h1 : sc_cnt_q + 32'h1;
      free_cnt_q <= free_evt ? 32'h1 : free_cnt_q + 32'h1;
    end
  end

  // Rescaled stream has no width of its own; a one-cycle level serves
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      sc_level_q <= 1'b0;
    else
      sc_level_q <= sc_event;
  end

  // ==========================================================================
  // Statistics engines
  tlac_trig_stats u_in_stats (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .event_pulse (in_event),
    .level       (trig_in),
    .stat        (in_stat)
  );

  tlac_trig_stats u_sc_stats (
    .core_clk    (core_clk),
    .sys_rst     (sys_rst),
    .event_pulse (sc_event),
    .level       (sc_level_q),
    .stat        (sc_stat)
  );

  // ==========================================================================
  // Readout: one column per cycle over the ROI; a new trigger mid-line is dropped
  always_comb begin
    rd_d = rd_q;
    case (rd_q)
      RD_IDLE: if (line_evt) rd_d = RD_PIX;
      RD_PIX:  if (col_q + 12'h1 >= roi_end) rd_d = RD_IDLE;
      default: rd_d = RD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q         <= RD_IDLE;
      col_q        <= 12'h0;
      run_q        <= 1'b0;
      line_start_q <= 1'b0;
    end else begin
      rd_q         <= rd_d;
      line_start_q <= (rd_q == RD_IDLE) && line_evt;
      run_q        <= rd_d == RD_PIX;
      if (rd_q == RD_IDLE)
        col_q <= cfg_q.offset_x;
      else
        col_q <= col_q + 12'h1;
    end
  end

  // Area mode row counter wraps at stage count; reverse mirrors it at row_index, which then counts down
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      row_q <= 7'h0;
    else if (!is_area)
      row_q <= 7'h0;
    else if ((rd_q == RD_IDLE) && line_evt)
      row_q <= (row_q + 7'h1 >= stages) ? 7'h0 : row_q + 7'h1;
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pix_valid    <= 1'b0;
      pix_col      <= 12'h0;
      row_index    <= 7'h0;
      row_reverse  <= 1'b0;
      scan_reverse <= 1'b0;
      accum_stages <= 7'h0;
      area_mode    <= 1'b0;
      line_start   <= 1'b0;
    end else begin
      pix_valid    <= rd_q == RD_PIX;
      pix_col      <= col_q;
      row_index    <= (is_area && dir_rev) ? 7'(stages - 7'h1 - row_q) : row_q;
      row_reverse  <= is_area && dir_rev;
      scan_reverse <= dir_rev;
      accum_stages <= is_area ? 7'h1 : stages;
      area_mode    <= is_area;
      line_start   <= line_start_q;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // tlac_top

// File: design/tlac_trig_stats.sv
// Period, frequency, variation and pulse width statistics for one trigger stream
module tlac_trig_stats
  import tlac_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Qualified trigger events and raw level
  input  wire logic        event_pulse,
  input  wire logic        level,
  // Results
  output tlac_stat_s       stat
);

  logic [31:0] per_cnt_q;
  logic [31:0] last_per_q;
  logic [31:0] hi_cnt_q;
  logic        level_q;
  logic        seen_q;
  logic [31:0] quo_q;
  logic [31:0] rem_q;
  logic [31:0] div_q;
  logic [5:0]  div_bit_q;
  logic        div_busy_q;
  tlac_stat_s  stat_q;

  // ==========================================================================
  // Variation: absolute period difference as percent of previous period
  wire [31:0] per_diff  = (per_cnt_q > last_per_q) ? per_cnt_q - last_per_q
                                                   : last_per_q - per_cnt_q;
  wire [38:0] diff_x100 = {7'h00, per_diff} * 39'd100;
  wire [38:0] var_q39   = (last_per_q == 32'h0000_0000) ? 39'h0 : diff_x100 / {7'h00, last_per_q};
  wire [7:0]  var_pct   = (var_q39 > 39'd255) ? 8'hff : var_q39[7:0];
  wire        timeout   = per_cnt_q >= TIMEOUT_CYC;
  wire [32:0] rem_shift = {rem_q, quo_q[31]};
  wire        rem_ge    = rem_shift >= {1'b0, div_q};

  // Period counter and event capture; a stalled stream reads as 0 Hz
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_q  <= 32'h0000_0000;
      last_per_q <= 32'h0000_0000;
      seen_q     <= 1'b0;
    end else if (event_pulse) begin
      per_cnt_q  <= 32'h0000_0001;
      last_per_q <= per_cnt_q;
      seen_q     <= 1'b1;
    end else if (!timeout) begin
      per_cnt_q  <= per_cnt_q + 32'h0000_0001;
    end
  end

  // Active high pulse width counter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_cnt_q <= 32'h0000_0000;
      level_q  <= 1'b0;
    end else begin
      level_q  <= level;
      hi_cnt_q <= (level && !level_q) ? 32'h0000_0001
                : (level && !timeout) ? hi_cnt_q + 32'h0000_0001 : hi_cnt_q;
    end
  end

  // Serial divider: CLK_HZ / period gives hertz, 32 cycles; an event within those 32 cycles restarts it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quo_q      <= 32'h0000_0000;
      rem_q      <= 32'h0000_0000;
      div_q      <= 32'h0000_0001;
      div_bit_q  <= 6'h00;
      div_busy_q <= 1'b0;
    end else if (event_pulse && seen_q && per_cnt_q != 32'h0000_0000) begin
      quo_q      <= CLK_HZ;
      rem_q      <= 32'h0000_0000;
      div_q      <= per_cnt_q;
      div_bit_q  <= 6'h20;
      div_busy_q <= 1'b1;
    end else if (div_busy_q) begin
      rem_q      <= rem_ge ? rem_shift[31:0] - div_q : rem_shift[31:0];
      quo_q      <= {quo_q[30:0], rem_ge};
      div_bit_q  <= div_bit_q - 6'h01;
      div_busy_q <= (div_bit_q != 6'h01);
    end
  end

  // Publish results once per measured period
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q <= '0;
    end else begin
      if (div_busy_q && div_bit_q == 6'h01) begin
        stat_q.freq_hz <= {quo_q[30:0], rem_ge};
        if ({quo_q[30:0], rem_ge} > stat_q.freq_peak_hz)
          stat_q.freq_peak_hz <= {quo_q[30:0], rem_ge};
      end else if (timeout) begin
        stat_q.freq_hz <= 32'h0000_0000;
      end
      if (event_pulse && seen_q)
        stat_q.variation_pct <= var_pct;
      if (!level && level_q)
        stat_q.width_us <= hi_cnt_q / CLK_PER_US;
    end
  end

  assign stat = stat_q;

endmodule // tlac_trig_stats
